/* hdl/clk_fanout_pkg.sv */
// types shared by the clock fanout control
package clk_fanout_pkg;
  typedef logic [3:0] ratio_code_t;
  typedef logic [7:0] cfg_byte_t;
  typedef logic [2:0] cfg_addr_t;
endpackage : clk_fanout_pkg

/* hdl/clk_fanout_regs.svh */
// register offsets, field positions and reset values of the clock fanout control
`ifndef CLK_FANOUT_REGS_SVH
`define CLK_FANOUT_REGS_SVH
`define GROUP_B_CFG_OFFSET     3'h2
`define GROUP_A_CFG_OFFSET     3'h4
`define HIGH_ENABLES_OFFSET    3'h5
`define LOW_ENABLES_OFFSET     3'h6
`define DIVIDER_ON_BIT         5
`define RATIO_CODE_LSB         0
`define GROUP_CFG_RESET        8'h30
`define HIGH_ENABLES_RESET     8'hff
`define LOW_ENABLES_RESET      8'hf0
`define HIGH_ENABLES_MASK      8'hbf
`define HIGH_RESERVED_ONES     8'h40
`define LOW_ENABLES_MASK       8'hff
`define GROUP_CFG_MASK         8'hff
`define RATIO_CODE_MAX         4'ha
`endif

/* hdl/clock_fanout_divider_control.sv */
// configuration bytes, output gating and two group dividers of the ten-output fanout
`timescale 1ns/1ps
`include "clk_fanout_regs.svh"
module clock_fanout_divider_control
  import clk_fanout_pkg::*;
#(
  parameter int GROUP_SIZE  = 5,  // outputs per divider group
  parameter int RATIO_WIDTH = 4   // width of a ratio code field
)
(
  input  wire logic                      sys_clk,      // system clock, 200 MHz
  input  wire logic                      srst,         // synchronous reset, active high
  input  wire logic                      cfg_wr,       // byte write strobe
  input  wire logic                      cfg_rd,       // byte read strobe
  input  wire clk_fanout_pkg::cfg_addr_t cfg_addr,     // byte offset
  input  wire clk_fanout_pkg::cfg_byte_t cfg_wdata,    // write byte
  output clk_fanout_pkg::cfg_byte_t      cfg_rdata,    // read byte, registered
  output logic                           cfg_rvalid,   // read data valid pulse
  output logic [9:0]                     clk_out_true, // gated output clocks
  output logic [9:0]                     clk_out_comp, // complement outputs
  output logic [9:0]                     out_drive_on  // effective enables per output
);
  import clk_fanout_pkg::*;

  localparam int N_OUTPUTS = 2 * GROUP_SIZE;

  // the byte map only has room for five outputs per group and a 4-bit code
  if (GROUP_SIZE != 5) begin : g_bad_group_size
    $error("group size must be five");
  end
  if (RATIO_WIDTH != 4) begin : g_bad_ratio_width
    $error("ratio code must be four bits");
  end

  // configuration bytes
  cfg_byte_t            group_a_cfg_reg;
  cfg_byte_t            group_b_cfg_reg;
  cfg_byte_t            high_enables_reg;
  cfg_byte_t            low_enables_reg;

  // write decode
  logic                 wr_group_a;
  logic                 wr_group_b;
  logic                 wr_high_enables;
  logic                 wr_low_enables;

  // read path
  cfg_byte_t            rdata_next;

  // dividers and gating
  logic                 group_a_divider;
  logic                 group_b_divider;
  logic                 group_a_divider_on;
  logic                 group_b_divider_on;
  logic [N_OUTPUTS-1:0] out_enable_bits;
  logic [N_OUTPUTS-1:0] group_divider_on;
  logic [N_OUTPUTS-1:0] group_level;
  logic [N_OUTPUTS-1:0] drive_next;
  logic [N_OUTPUTS-1:0] true_next;
  logic [N_OUTPUTS-1:0] comp_next;

  // one strobe per mapped byte, unmapped offsets are ignored
  always_comb begin
    wr_group_a      = cfg_wr && (cfg_addr == `GROUP_A_CFG_OFFSET);
    wr_group_b      = cfg_wr && (cfg_addr == `GROUP_B_CFG_OFFSET);
    wr_high_enables = cfg_wr && (cfg_addr == `HIGH_ENABLES_OFFSET);
    wr_low_enables  = cfg_wr && (cfg_addr == `LOW_ENABLES_OFFSET);
  end

  // group A byte: divider on bit and ratio code, used at once
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      group_a_cfg_reg <= `GROUP_CFG_RESET;
    end else if (wr_group_a) begin
      group_a_cfg_reg <= cfg_wdata & `GROUP_CFG_MASK;
    end
  end

  // group B byte: divider on bit and ratio code, used at once
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      group_b_cfg_reg <= `GROUP_CFG_RESET;
    end else if (wr_group_b) begin
      group_b_cfg_reg <= cfg_wdata & `GROUP_CFG_MASK;
    end
  end

  // upper enables byte, reserved bit six stays one
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      high_enables_reg <= `HIGH_ENABLES_RESET;
    end else if (wr_high_enables) begin
      high_enables_reg <= (cfg_wdata & `HIGH_ENABLES_MASK) | `HIGH_RESERVED_ONES;
    end
  end

  // lower enables byte
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      low_enables_reg <= `LOW_ENABLES_RESET;
    end else if (wr_low_enables) begin
      low_enables_reg <= cfg_wdata & `LOW_ENABLES_MASK;
    end
  end

  // read selection, unmapped offsets read zero
  always_comb begin
    case (cfg_addr)
      `GROUP_B_CFG_OFFSET:  rdata_next = group_b_cfg_reg;
      `GROUP_A_CFG_OFFSET:  rdata_next = group_a_cfg_reg;
      `HIGH_ENABLES_OFFSET: rdata_next = high_enables_reg;
      `LOW_ENABLES_OFFSET:  rdata_next = low_enables_reg;
      default:              rdata_next = 8'h00;
    endcase
  end

  // read byte holds until the next read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      cfg_rdata <= rdata_next;
    end
  end

  // one-cycle valid pulse after each read strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
    end
  end

  // the two group dividers free-run whatever the gating
  group_divider u_group_a (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .ratio_code (group_a_cfg_reg[`RATIO_CODE_LSB +: 4]),
    .div_out    (group_a_divider)
  );

  group_divider u_group_b (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .ratio_code (group_b_cfg_reg[`RATIO_CODE_LSB +: 4]),
    .div_out    (group_b_divider)
  );

  // divider on bits of both group bytes
  always_comb begin
    group_a_divider_on = group_a_cfg_reg[`DIVIDER_ON_BIT];
    group_b_divider_on = group_b_cfg_reg[`DIVIDER_ON_BIT];
  end

  // per-output enable bits, gathered into output order
  always_comb begin
    out_enable_bits[0] = low_enables_reg[4];
    out_enable_bits[1] = low_enables_reg[5];
    out_enable_bits[2] = low_enables_reg[6];
    out_enable_bits[3] = low_enables_reg[7];
    out_enable_bits[4] = high_enables_reg[0];
    out_enable_bits[5] = high_enables_reg[1];
    out_enable_bits[6] = high_enables_reg[2];
    out_enable_bits[7] = high_enables_reg[3];
    out_enable_bits[8] = high_enables_reg[4];
    out_enable_bits[9] = high_enables_reg[5];
  end

  // each output sees its own group's divider level and on bit
  always_comb begin
    group_divider_on = {{GROUP_SIZE{group_b_divider_on}}, {GROUP_SIZE{group_a_divider_on}}};
    group_level      = {{GROUP_SIZE{group_b_divider}}, {GROUP_SIZE{group_a_divider}}};
  end

  // per-output gating: an output only looks at its own bit, so a write
  // to one enable never interrupts the others
  always_comb begin
    for (int i = 0; i < N_OUTPUTS; i++) begin
      drive_next[i] = out_enable_bits[i] & group_divider_on[i];
      true_next[i]  = group_level[i] & drive_next[i];
      comp_next[i]  = ~group_level[i] & drive_next[i];
    end
  end

  // effective enables, disabled pairs idle with both legs low
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      out_drive_on <= 10'h000;
    end else begin
      out_drive_on <= drive_next;
    end
  end

  // true leg, ratio one shows a steady high level
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_out_true <= 10'h000;
    end else begin
      clk_out_true <= true_next;
    end
  end

  // complement leg
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_out_comp <= 10'h000;
    end else begin
      clk_out_comp <= comp_next;
    end
  end
endmodule : clock_fanout_divider_control

/* hdl/group_divider.sv */
// one group divider: ratio decode and counter producing a divided clock level
`timescale 1ns/1ps
`include "clk_fanout_regs.svh"
module group_divider
  import clk_fanout_pkg::*;
(
  input  wire logic        sys_clk,     // system clock
  input  wire logic        srst,        // synchronous reset
  input  wire ratio_code_t ratio_code,  // 4-bit ratio select
  output logic             div_out      // divided clock level
);
  logic [6:0] ratio;
  logic [6:0] count_reg;
  logic       div_out_next;
  logic       ratio_one;

  // code to division ratio
  always_comb begin
    case (ratio_code)
      4'h0:    ratio = 7'd1;
      4'h1:    ratio = 7'd2;
      4'h2:    ratio = 7'd4;
      4'h3:    ratio = 7'd5;
      4'h4:    ratio = 7'd8;
      4'h5:    ratio = 7'd10;
      4'h6:    ratio = 7'd16;
      4'h7:    ratio = 7'd20;
      4'h8:    ratio = 7'd32;
      4'h9:    ratio = 7'd40;
      4'ha:    ratio = 7'd80;
      default: ratio = 7'd1;  // reserved codes fall back to divide by one
    endcase
  end

  assign ratio_one = (ratio == 7'd1);

  // new ratio used at once, no resync; phase between groups not kept
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count_reg <= 7'h00;
    end else if (count_reg >= ratio - 7'd1) begin
      count_reg <= 7'h00;
    end else begin
      count_reg <= count_reg + 7'd1;
    end
  end

  // high for first half of the period, ratio one stays high, odd ratio five gets the shorter high
  always_comb begin
    if (ratio_one) begin
      div_out_next = 1'b1;
    end else begin
      div_out_next = (count_reg < (ratio >> 1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_out <= 1'b0;
    end else begin
      div_out <= div_out_next;
    end
  end
endmodule : group_divider

/* testbench/cfg_host.sv */
// host model issuing configuration byte writes and reads
`timescale 1ns/1ps
module cfg_host
  import clk_fanout_pkg::*;
(
  input  wire logic      sys_clk,   // clock
  input  wire cfg_byte_t cfg_rdata, // read byte
  output cfg_byte_t      cfg_wdata, // write byte
  output cfg_addr_t      cfg_addr,  // offset
  output logic           cfg_wr,    // write strobe
  output logic           cfg_rd     // read strobe
);
  initial begin
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = '0;
  end
  task wr(input cfg_addr_t a, input cfg_byte_t d);
    @(posedge sys_clk);
    {cfg_wr, cfg_addr, cfg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    {cfg_wr, cfg_wdata} <= {1'b0, ~d};
  endtask : wr
  task rd(input cfg_addr_t a, output cfg_byte_t d);
    @(posedge sys_clk);
    {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1 d = cfg_rdata;
  endtask : rd
endmodule : cfg_host

/* testbench/clock_fanout_divider_control_tb.sv */
// self-checking bench of the clock fanout control
`timescale 1ns/1ps
module clock_fanout_divider_control_tb;
  import clk_fanout_pkg::*;
  logic sys_clk, srst, cfg_wr, cfg_rd, cfg_rvalid;
  cfg_addr_t cfg_addr;
  cfg_byte_t cfg_wdata, cfg_rdata, b;
  logic [9:0] clk_out_true, clk_out_comp, out_drive_on;
  int failures, n_compared, cyc, r, k, n;
  int n_tab[10] = '{2, 4, 5, 8, 10, 16, 20, 32, 40, 80};
  cfg_byte_t rv[6] = '{8'h30, 8'h30, 8'hff, 8'hf0, 8'h00, 8'h00};
  cfg_addr_t ra[6] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h0, 3'h7};
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  clock_fanout_divider_control i_dut (.sys_clk(sys_clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .clk_out_true(clk_out_true), .clk_out_comp(clk_out_comp), .out_drive_on(out_drive_on));
  cfg_host i_host (.sys_clk(sys_clk), .cfg_rdata(cfg_rdata), .cfg_wdata(cfg_wdata), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd));
  task chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // rising edges of one output over 160 cycles, sampled just after each edge
  task rises(input int i, output int cnt);
    logic prev;
    cnt = 0;
    @(posedge sys_clk);
    #1 prev = clk_out_true[i];
    repeat (160) begin
      @(posedge sys_clk);
      #1 if (clk_out_true[i] === 1'b1 && prev === 1'b0) cnt++;
      prev = clk_out_true[i];
    end
  endtask : rises
  task settle(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask : settle
  task final_report;
    $display("compared %0d, mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    srst = 1'b1;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    settle(2);
    chk(out_drive_on, 10'h3ff);
    chk(clk_out_true, 10'h3ff);
    chk(clk_out_comp, 10'h000);
    for (r = 0; r < 6; r++) begin
      i_host.rd(ra[r], b);
      chk(b, rv[r]);
      chk(cfg_rvalid, 1'b1);
    end
    $display("test reset defaults done");
    i_host.wr(3'h6, 8'h50);
    settle(2);
    chk(out_drive_on, 10'h3f5);
    chk(clk_out_true, 10'h3f5);
    chk(clk_out_comp, 10'h000);
    i_host.wr(3'h5, 8'h15);
    settle(2);
    chk(out_drive_on, 10'h155);
    i_host.rd(3'h5, b);
    chk(b, 8'h55);
    i_host.wr(3'h5, 8'hbf);
    i_host.wr(3'h6, 8'hf0);
    i_host.wr(3'h3, 8'hff);
    i_host.rd(3'h3, b);
    chk(b, 8'h00);
    $display("test enables done");
    i_host.wr(3'h2, 8'h10);
    settle(2);
    chk(out_drive_on, 10'h01f);
    chk(clk_out_true, 10'h01f);
    i_host.wr(3'h4, 8'h10);
    settle(2);
    chk(out_drive_on, 10'h000);
    i_host.wr(3'h2, 8'h30);
    i_host.wr(3'h4, 8'h30);
    $display("test group off done");
    for (k = 0; k < 10; k++) begin
      i_host.wr(3'h4, 8'h31 + 8'(k));
      settle(100);
      rises(0, n);
      chk(10'(n), 10'(160 / n_tab[k]));
    end
    $display("test ratios done");
    i_host.wr(3'h4, 8'h32);
    settle(100);
    fork
      rises(0, n);
      begin
        repeat (3) begin
          i_host.wr(3'h6, 8'hd0);
          i_host.wr(3'h6, 8'hf0);
        end
      end
    join
    chk(10'(n), 10'd40);
    chk(clk_out_true ^ clk_out_comp, 10'h3ff);
    i_host.wr(3'h2, 8'h31);
    settle(100);
    fork
      rises(5, n);
      begin
        i_host.wr(3'h4, 8'h34);
        i_host.wr(3'h4, 8'h32);
      end
    join
    chk(10'(n), 10'd80);
    $display("test non-disruptive done");
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    settle(2);
    chk(out_drive_on, 10'h3ff);
    i_host.rd(3'h4, b);
    chk(b, 8'h30);
    $display("test mid reset done");
    final_report();
  end
endmodule : clock_fanout_divider_control_tb

/* testbench/fanout_ctl_assertions.sv */
// port assertions for the clock fanout control
`timescale 1ns/1ps
module fanout_ctl_assertions
  import clk_fanout_pkg::*;
(
  input wire logic       sys_clk,      // clock
  input wire logic       srst,         // reset
  input wire logic       cfg_wr,       // write
  input wire logic       cfg_rd,       // read
  input wire cfg_addr_t  cfg_addr,     // offset
  input wire cfg_byte_t  cfg_wdata,    // wdata
  input wire cfg_byte_t  cfg_rdata,    // rdata
  input wire logic       cfg_rvalid,   // valid
  input wire logic [9:0] clk_out_true, // clocks
  input wire logic [9:0] clk_out_comp, // complements
  input wire logic [9:0] out_drive_on  // enables
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  high_gate_a: assert property (cfg_wr && cfg_addr == 3'h5 |-> ##2
    (out_drive_on[9:4] & ~$past(cfg_wdata[5:0], 2)) == 6'h0) else $error("upper gate");
  low_gate_a: assert property (cfg_wr && cfg_addr == 3'h6 |-> ##2
    (out_drive_on[3:0] & ~$past(cfg_wdata[7:4], 2)) == 4'h0) else $error("lower gate");
  group_a_off_a: assert property (cfg_wr && cfg_addr == 3'h4 && !cfg_wdata[5] |-> ##2
    out_drive_on[4:0] == 5'h0) else $error("group a off");
  group_b_off_a: assert property (cfg_wr && cfg_addr == 3'h2 && !cfg_wdata[5] |-> ##2
    out_drive_on[9:5] == 5'h0) else $error("group b off");
  idle_low_a: assert property (((clk_out_true | clk_out_comp) & ~out_drive_on) == 10'h0) else $error("idle");
  read_pulse_a: assert property (cfg_rvalid == $past(cfg_rd)) else $error("read valid");
  unmapped_read_a: assert property (cfg_rd && cfg_addr inside {3'h0, 3'h1, 3'h3, 3'h7} |=>
    cfg_rdata == 8'h0) else $error("unmapped read");
  reset_on_a: assert property ($fell(srst) |=> out_drive_on == 10'h3ff) else $error("reset");
endmodule : fanout_ctl_assertions
bind clock_fanout_divider_control fanout_ctl_assertions i_chk (.sys_clk(sys_clk), .srst(srst), .cfg_wr(cfg_wr),
  .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .clk_out_true(clk_out_true), .clk_out_comp(clk_out_comp), .out_drive_on(out_drive_on));
